// ==== rtl/rtseq_regs.vh ====
`ifndef RTSEQ_REGS_VH
`define RTSEQ_REGS_VH

// Register byte addresses
`define RTSEQ_CAUSE_ADDR     12'h000
`define RTSEQ_STATUS_ADDR    12'h004
`define RTSEQ_PC_ADDR        12'h008
`define RTSEQ_CTRL_ADDR      12'h00C
`define RTSEQ_IRQ_ST_ADDR    12'h010
`define RTSEQ_IRQ_MASK_ADDR  12'h014
`define RTSEQ_SEQ_ADDR       12'h018

// Cause register fields (active-low flags)
`define RTSEQ_CAUSE_BO_BIT   0
`define RTSEQ_CAUSE_PO_BIT   1
`define RTSEQ_CAUSE_RESET    8'h01

// Status register field positions
`define RTSEQ_STAT_PD_BIT    3
`define RTSEQ_STAT_TO_BIT    4

// Control register fields
`define RTSEQ_CTRL_PDE_N_BIT 0
`define RTSEQ_CTRL_RCOSC_BIT 1
`define RTSEQ_CTRL_BODEN_BIT 2
`define RTSEQ_CTRL_GIE_BIT   3
`define RTSEQ_CTRL_RESET     8'h05

// Event bits in interrupt status
`define RTSEQ_EV_POR         0
`define RTSEQ_EV_BOR         1
`define RTSEQ_EV_WDT_RST     2
`define RTSEQ_EV_WDT_WAKE    3
`define RTSEQ_EV_CLR_RST     4
`define RTSEQ_EV_IRQ_WAKE    5
`define RTSEQ_EV_RUN         6

// Program counter values
`define RTSEQ_PC_RESET       13'h0000
`define RTSEQ_PC_VECTOR      13'h0004

// Timing
`define RTSEQ_POWER_UP_DELAY_TIMER_MS        72
`define RTSEQ_CLK_MHZ        125
`define RTSEQ_POWER_UP_DELAY_TIMER_CYCLES    (`RTSEQ_POWER_UP_DELAY_TIMER_MS * 1000 * `RTSEQ_CLK_MHZ)
`define RTSEQ_OST_PERIODS    1024

`endif

// ==== rtl/rtseq_sync.v ====
`timescale 1ns/1ps
module rtseq_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // Reset value 0 reads as "clear pin low" until synchronised
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule

// ==== rtl/rtseq_timer.v ====
`timescale 1ns/1ps
module rtseq_timer #(
    parameter W = 24
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         start,
    input  wire [W-1:0] load,
    output wire         busy,
    output wire         done
);
    reg [W-1:0] cnt_reg;
    reg         busy_reg;
    reg         done_reg;

    // A zero load finishes on the next edge, so a skipped phase costs one cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= {W{1'b0}};
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start) begin
                cnt_reg  <= load;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                if (cnt_reg <= {{(W-1){1'b0}}, 1'b1}) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                    cnt_reg  <= {W{1'b0}};
                end else begin
                    cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
endmodule

// ==== rtl/rtseq_top.v ====
// How it works
// R01 - Delay timer first, then oscillator start-up
// R02 - RC mode, delay off: no time-out
// R03 - Time-outs ignore clear pin; release runs
// R04 - Time-out lengths per oscillator and cause
// R05 - Bit0 brown-out flag, low after brown-out
// R06 - Brown-out detection off: flag is unknown
// R07 - Bit1 power-on flag cleared on power-on
// R08 - Cause encoded by four flags
// R09 - Power-on always sets timeout flag
// R10 - Power-on always sets power-down flag
// R11 - PC zero on reset, plus one on wake
// R12 - Interrupt wake with enable loads vector
// R13 - Cause register values per condition
// R14 - Execution held until all releases
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "rtseq_regs.vh"
module rtseq_top #(
    parameter [23:0] POWER_UP_DELAY_TIMER_CYCLES = `RTSEQ_POWER_UP_DELAY_TIMER_CYCLES,
    parameter [23:0] OST_CYCLES  = `RTSEQ_OST_PERIODS
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        por_pulse,
    input  wire        bor_pulse,
    input  wire        external_clear_pin_n,
    input  wire        wdt_reset,
    input  wire        wdt_wake,
    input  wire        irq_wake,
    input  wire        sleeping,
    input  wire [12:0] cur_pc,
    output reg         core_reset_n,
    output reg  [12:0] pc_load,
    output reg         pc_load_strobe,
    output reg         irq
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_POWER_UP_DELAY_TIMER = 3'd1;
    localparam [2:0] ST_OST  = 3'd2;
    localparam [2:0] ST_CLR  = 3'd3;
    localparam [2:0] ST_RUN  = 3'd4;

    wire [5:0] raw_in;
    wire [5:0] sync_in;
    assign raw_in = {irq_wake, wdt_wake, wdt_reset, bor_pulse, por_pulse,
                     external_clear_pin_n};

    // Every asynchronous input passes two flops before any edge detect
    rtseq_sync #(.W(6)) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     (raw_in),
        .q     (sync_in)
    );

    wire clr_n  = sync_in[0];
    wire por_s  = sync_in[1];
    wire bor_s  = sync_in[2];
    wire wdtr_s = sync_in[3];
    wire wdtw_s = sync_in[4];
    wire irqw_s = sync_in[5];

    reg  [5:0] prev_reg;
    wire [5:0] rise = sync_in & ~prev_reg;
    wire       clr_fall = prev_reg[0] & ~clr_n;

    reg  [2:0]  state_reg;
    reg  [7:0]  cause_reg;
    reg  [7:0]  status_reg;
    reg  [7:0]  ctrl_reg;
    reg  [6:0]  irq_st_reg;
    reg  [6:0]  irq_mask_reg;
    reg  [23:0] ost_load_reg;
    reg         power_up_delay_timer_start;
    reg         ost_start;
    wire        power_up_delay_timer_done;
    wire        ost_done;
    wire        power_up_delay_timer_busy;
    wire        ost_busy;

    wire pde_n  = ctrl_reg[`RTSEQ_CTRL_PDE_N_BIT];
    wire rc_osc = ctrl_reg[`RTSEQ_CTRL_RCOSC_BIT];
    wire boden  = ctrl_reg[`RTSEQ_CTRL_BODEN_BIT];
    wire global_irq_enable    = ctrl_reg[`RTSEQ_CTRL_GIE_BIT];

    // The delay length is fixed; only whether it runs depends on control bits
    rtseq_timer #(.W(24)) u_power_up_delay_timer (
        .clk   (pclk),
        .rst_n (presetn),
        .start (power_up_delay_timer_start),
        .load  (POWER_UP_DELAY_TIMER_CYCLES),
        .busy  (power_up_delay_timer_busy),
        .done  (power_up_delay_timer_done)
    );

    rtseq_timer #(.W(24)) u_ost (
        .clk   (pclk),
        .rst_n (presetn),
        .start (ost_start),
        .load  (ost_load_reg),
        .busy  (ost_busy),
        .done  (ost_done)
    );

    // Crystal modes need the start-up count; RC mode has none
    function [23:0] ost_len;
        input rc;
        begin
            ost_len = rc ? 24'h00_0000 : OST_CYCLES;
        end
    endfunction

    // Only the seven word offsets answer without an error
    function addr_known;
        input [11:0] a;
        begin
            if (a == `RTSEQ_CAUSE_ADDR)
                addr_known = 1'b1;
            else if (a == `RTSEQ_STATUS_ADDR)
                addr_known = 1'b1;
            else if (a == `RTSEQ_PC_ADDR)
                addr_known = 1'b1;
            else if (a == `RTSEQ_CTRL_ADDR)
                addr_known = 1'b1;
            else if (a == `RTSEQ_IRQ_ST_ADDR)
                addr_known = 1'b1;
            else if (a == `RTSEQ_IRQ_MASK_ADDR)
                addr_known = 1'b1;
            else if (a == `RTSEQ_SEQ_ADDR)
                addr_known = 1'b1;
            else
                addr_known = 1'b0;
        end
    endfunction

    wire wr_en = psel & penable & pwrite & pready;
    wire rd_en = psel & ~penable & ~pwrite;

    // Only a completed write access clears status bits
    wire w1c_hit = wr_en && (paddr == `RTSEQ_IRQ_ST_ADDR);
    wire [6:0] w1c = w1c_hit ? pwdata[6:0] : 7'h00;

    reg [6:0] ev;
    reg       wake;

    always @* begin
        ev = 7'h00;
        ev[`RTSEQ_EV_POR]      = rise[1];
        ev[`RTSEQ_EV_BOR]      = rise[2] & boden;
        ev[`RTSEQ_EV_WDT_RST]  = rise[3] & ~sleeping;
        ev[`RTSEQ_EV_WDT_WAKE] = rise[4] & sleeping;
        ev[`RTSEQ_EV_CLR_RST]  = clr_fall;
        ev[`RTSEQ_EV_IRQ_WAKE] = rise[5] & sleeping;
        ev[`RTSEQ_EV_RUN]      = (state_reg != ST_RUN) && (state_reg != ST_IDLE) &&
                                 clr_n && !power_up_delay_timer_busy && !ost_busy &&
                                 !power_up_delay_timer_start && !ost_start && state_reg == ST_CLR;
        wake = ev[`RTSEQ_EV_WDT_WAKE] | ev[`RTSEQ_EV_IRQ_WAKE];
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Matches the synchroniser reset, so no false clear-pin edge follows reset
            prev_reg       <= 6'h00;
            state_reg      <= ST_IDLE;
            cause_reg      <= `RTSEQ_CAUSE_RESET;
            status_reg     <= 8'h18;
            ctrl_reg       <= `RTSEQ_CTRL_RESET;
            irq_st_reg     <= 7'h00;
            irq_mask_reg   <= 7'h00;
            ost_load_reg   <= 24'h00_0000;
            power_up_delay_timer_start     <= 1'b0;
            ost_start      <= 1'b0;
            core_reset_n   <= 1'b0;
            pc_load        <= `RTSEQ_PC_RESET;
            pc_load_strobe <= 1'b0;
            irq            <= 1'b0;
            pready         <= 1'b0;
            pslverr        <= 1'b0;
            prdata         <= 32'h0000_0000;
        end else begin
            prev_reg       <= sync_in;
            power_up_delay_timer_start     <= 1'b0;
            ost_start      <= 1'b0;
            pc_load_strobe <= 1'b0;
            // Set beats write-one-to-clear in the same cycle
            irq_st_reg <= (irq_st_reg & ~w1c) | ev;
            irq        <= |(((irq_st_reg & ~w1c) | ev) & irq_mask_reg);

            case (state_reg)
                ST_IDLE, ST_RUN: begin
                    if (ev[`RTSEQ_EV_POR] || ev[`RTSEQ_EV_BOR]) begin
                        core_reset_n <= 1'b0;
                        // Skip the delay timer when it is disabled, except on a brown-out without power-on
                        if (!pde_n) begin // [R01] [R04]
                            power_up_delay_timer_start <= 1'b1;
                            state_reg  <= ST_POWER_UP_DELAY_TIMER;
                        end else if (ev[`RTSEQ_EV_BOR] && !ev[`RTSEQ_EV_POR]) begin
                            power_up_delay_timer_start <= 1'b1; // [R04]
                            state_reg  <= ST_POWER_UP_DELAY_TIMER;
                        end else begin
                            ost_start <= 1'b1; // [R02]
                            state_reg <= ST_OST;
                        end
                        ost_load_reg <= ost_len(rc_osc); // [R04]
                    end else if (wake) begin
                        // A wake reruns only the start-up count, never the delay
                        core_reset_n <= 1'b0;
                        ost_load_reg <= ost_len(rc_osc); // [R04]
                        ost_start    <= 1'b1;
                        state_reg    <= ST_OST;
                    end else if (ev[`RTSEQ_EV_WDT_RST] || (clr_fall && state_reg == ST_RUN)) begin
                        // Pin and watchdog resets skip both timers and wait for the pin
                        core_reset_n <= 1'b0;
                        state_reg    <= ST_CLR;
                    end
                end
                ST_POWER_UP_DELAY_TIMER: if (power_up_delay_timer_done) begin
                    ost_start <= 1'b1; // [R01]
                    state_reg <= ST_OST;
                end
                ST_OST: if (ost_done) state_reg <= ST_CLR;
                ST_CLR: if (clr_n) begin
                    // Time-outs already spent, so release runs at once
                    core_reset_n   <= 1'b1; // [R03] [R14]
                    pc_load_strobe <= 1'b1;
                    state_reg      <= ST_RUN;
                end
                default: state_reg <= ST_IDLE;
            endcase

            if (ev[`RTSEQ_EV_POR]) begin
                pc_load    <= `RTSEQ_PC_RESET; // [R11]
                status_reg <= {3'b000, 1'b1, 1'b1, status_reg[2:0]}; // [R09] [R10] [R08]
                // With detection off the brown-out flag is left as it was
                cause_reg  <= {cause_reg[7:2], 1'b0, boden | cause_reg[0]}; // [R07] [R06] [R13]
            end else if (ev[`RTSEQ_EV_BOR]) begin
                pc_load    <= `RTSEQ_PC_RESET;
                status_reg <= {3'b000, 1'b1, 1'b1, status_reg[2:0]}; // [R08]
                cause_reg  <= {cause_reg[7:1], 1'b0}; // [R05] [R13]
            end else if (ev[`RTSEQ_EV_WDT_RST]) begin
                pc_load    <= `RTSEQ_PC_RESET;
                status_reg <= {3'b000, 1'b0, 1'b1, status_reg[2:0]}; // [R08]
            end else if (ev[`RTSEQ_EV_WDT_WAKE]) begin
                pc_load    <= cur_pc + 13'h0001; // [R11]
                status_reg <= {status_reg[7:5], 1'b0, 1'b0, status_reg[2:0]}; // [R08]
            end else if (ev[`RTSEQ_EV_IRQ_WAKE]) begin
                pc_load    <= global_irq_enable ? `RTSEQ_PC_VECTOR : cur_pc + 13'h0001; // [R12] [R11]
                status_reg <= {status_reg[7:5], 1'b1, 1'b0, status_reg[2:0]}; // [R08]
            end else if (clr_fall && state_reg == ST_RUN) begin
                pc_load <= `RTSEQ_PC_RESET;
                if (sleeping)
                    status_reg <= {3'b000, 1'b1, 1'b0, status_reg[2:0]}; // [R08]
                else
                    status_reg <= {3'b000, status_reg[4:0]};
            end

            // Every transfer ends in its access cycle; no wait states
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pready <= 1'b1;
                if (!addr_known(paddr))
                    pslverr <= 1'b1;
            end
            // Read data is taken in the setup cycle and stands through the access
            if (rd_en) begin
                if (paddr == `RTSEQ_CAUSE_ADDR)
                    prdata <= {24'h00_0000, cause_reg};
                else if (paddr == `RTSEQ_STATUS_ADDR)
                    prdata <= {24'h00_0000, status_reg};
                else if (paddr == `RTSEQ_PC_ADDR)
                    prdata <= {19'h0_0000, pc_load};
                else if (paddr == `RTSEQ_CTRL_ADDR)
                    prdata <= {24'h00_0000, ctrl_reg};
                else if (paddr == `RTSEQ_IRQ_ST_ADDR)
                    prdata <= {25'h000_0000, irq_st_reg};
                else if (paddr == `RTSEQ_IRQ_MASK_ADDR)
                    prdata <= {25'h000_0000, irq_mask_reg};
                else if (paddr == `RTSEQ_SEQ_ADDR)
                    prdata <= {28'h000_0000, core_reset_n, state_reg};
                else
                    prdata <= 32'h0000_0000;
            end
            if (wr_en) begin
                // Software sets the flags back after each reset
                if (paddr == `RTSEQ_CAUSE_ADDR && !ev[`RTSEQ_EV_POR] && !ev[`RTSEQ_EV_BOR])
                    cause_reg <= {6'h00, pwdata[1:0]}; // [R05] [R07]
                else if (paddr == `RTSEQ_CTRL_ADDR)
                    ctrl_reg <= {4'h0, pwdata[3:0]};
                else if (paddr == `RTSEQ_IRQ_MASK_ADDR)
                    irq_mask_reg <= pwdata[6:0];
            end
        end
    end
endmodule

// ==== sim/rtseq_asserts.sv ====
`timescale 1ns/1ps
module rtseq_asserts (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pready,
    input logic        pslverr,
    input logic        por_pulse,
    input logic        external_clear_pin_n,
    input logic        sleeping,
    input logic        core_reset_n,
    input logic [12:0] pc_load,
    input logic        pc_load_strobe,
    input logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pready_in_access: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    a_pready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_strobe_single: assert property (pc_load_strobe |=> !pc_load_strobe)
        else $error("pc load strobe too long");
    a_release_with_strobe: assert property ($rose(core_reset_n) |-> ##[0:1] pc_load_strobe)
        else $error("release without pc load");
    a_release_pin_high: assert property ($rose(core_reset_n) |-> external_clear_pin_n)
        else $error("release while clear pin low");
    a_reset_pc_zero: assert property (pc_load_strobe && !sleeping |-> pc_load == 13'h0000)
        else $error("reset pc not zero");
    a_por_enters_reset: assert property ($rose(por_pulse) |-> ##[1:6] !core_reset_n)
        else $error("power-on pulse did not reset core");
    a_pin_low_resets: assert property (!external_clear_pin_n [*6] |-> !core_reset_n)
        else $error("clear pin low but core running");

    c_release: cover property ($rose(core_reset_n));
    c_slverr: cover property (pslverr);
    c_wake: cover property (pc_load_strobe && sleeping);
    c_irq: cover property ($rose(irq));
endmodule

bind rtseq_top rtseq_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .por_pulse(por_pulse), .external_clear_pin_n(external_clear_pin_n),
    .sleeping(sleeping), .core_reset_n(core_reset_n), .pc_load(pc_load),
    .pc_load_strobe(pc_load_strobe), .irq(irq)
);

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`include "rtseq_regs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %0t got %0h want %0h", $time, g, e); end end
module tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin_n = 1, sleeping = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
    logic        pready, pslverr, serr, core_reset_n, pc_load_strobe, irq;
    logic [12:0] cur_pc = 13'h0000, pc_load, pc;
    logic [4:0]  ev = 5'h00;
    int          failures = 0, samples_checked = 0, cyc = 0, n;
    // Nominal time-out plus up to 12 cycles of sync, edge and phase hand-off
    int          tbl [4][4] = '{'{0, 0, 28, 40}, '{1, 0, 8, 20}, '{0, 1, 20, 32}, '{1, 1, 0, 12}};

    rtseq_top #(.POWER_UP_DELAY_TIMER_CYCLES(24'h00_0014), .OST_CYCLES(24'h00_0008)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .por_pulse(ev[0]), .bor_pulse(ev[1]), .external_clear_pin_n(pin_n),
        .wdt_reset(ev[2]), .wdt_wake(ev[3]), .irq_wake(ev[4]), .sleeping(sleeping),
        .cur_pc(cur_pc), .core_reset_n(core_reset_n), .pc_load(pc_load),
        .pc_load_strobe(pc_load_strobe), .irq(irq));

    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (failures == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // Only the bench timeout ends a wait for pready
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // Strobe is the release marker, so n counts event edge to release
    task automatic wait_strobe();
        while (pc_load_strobe !== 1'b1 && n < 300) begin @(posedge pclk); n++; end
        pc = pc_load;
    endtask

    task automatic fire(input int k);
        n = 3;
        ev[k] <= 1'b1;
        repeat (3) @(posedge pclk);
        ev[k] <= 1'b0;
        wait_strobe();
    endtask

    task automatic flags(input logic [1:0] cause, input logic [1:0] stat);
        apb(0, `RTSEQ_CAUSE_ADDR, 0);
        `CHK(rdat[1:0], cause)
        apb(0, `RTSEQ_STATUS_ADDR, 0);
        `CHK(rdat[4:3], stat)
    endtask

    task automatic t_power_on();
        for (int i = 0; i < 4; i++) begin
            apb(1, `RTSEQ_CTRL_ADDR, 32'h0000_0004 | tbl[i][0] | (tbl[i][1] << 1));
            apb(1, `RTSEQ_CAUSE_ADDR, 32'h0000_0003);
            fire(0);
            `CHK(n >= tbl[i][2] && n <= tbl[i][3], 1'b1)
            `CHK(pc, 13'h0000)
            flags(2'b01, 2'b11);
            `CHK(rdat[7:3], 5'b00011)
        end
    endtask

    task automatic t_pin_hold();
        pin_n <= 0;
        fire(0);
        `CHK(core_reset_n, 1'b0)
        pin_n <= 1;
        n = 0;
        wait_strobe();
        `CHK(n <= 5, 1'b1)
    endtask

    task automatic t_resets();
        apb(1, `RTSEQ_CTRL_ADDR, 32'h0000_0004);
        apb(1, `RTSEQ_CAUSE_ADDR, 32'h0000_0003);
        fire(1);
        `CHK(n >= 28 && n <= 40, 1'b1)
        flags(2'b10, 2'b11);
        fire(2);
        `CHK(pc, 13'h0000)
        flags(2'b10, 2'b01);
    endtask

    task automatic t_wakes();
        sleeping <= 1;
        cur_pc <= 13'h0123;
        fire(3);
        `CHK(n >= 8 && n <= 20, 1'b1)
        `CHK(pc, 13'h0124)
        flags(2'b10, 2'b00);
        fire(4);
        `CHK(pc, 13'h0124)
        flags(2'b10, 2'b10);
        apb(1, `RTSEQ_CTRL_ADDR, 32'h0000_000C);
        fire(4);
        `CHK(pc, `RTSEQ_PC_VECTOR)
        pin_n <= 0;
        repeat (8) @(posedge pclk);
        pin_n <= 1;
        n = 0;
        wait_strobe();
        `CHK(pc, 13'h0000)
        flags(2'b10, 2'b10);
        sleeping <= 0;
    endtask

    task automatic t_irq();
        apb(1, `RTSEQ_IRQ_MASK_ADDR, 32'h0000_0000);
        apb(1, `RTSEQ_IRQ_ST_ADDR, 32'h0000_007F);
        fire(2);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(0, `RTSEQ_IRQ_ST_ADDR, 0);
        `CHK(rdat[`RTSEQ_EV_WDT_RST], 1'b1)
        apb(1, `RTSEQ_IRQ_MASK_ADDR, 32'h0000_007F);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1, `RTSEQ_IRQ_ST_ADDR, 32'h0000_007F);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        apb(0, `RTSEQ_CAUSE_ADDR, 0);
        `CHK(rdat, 32'h0000_0001)
        apb(0, `RTSEQ_CTRL_ADDR, 0);
        `CHK(rdat, 32'h0000_0005)
        apb(0, 12'hFFC, 0);
        `CHK(serr, 1'b1)
        `CHK(core_reset_n, 1'b0)
        t_power_on();
        t_pin_hold();
        t_resets();
        t_wakes();
        t_irq();
        end_sim();
    end
endmodule
